// ==== design/acccr_bank_if.sv ====
// Connection between the bus front end and the trim register bank
`timescale 1ns/1ps
interface acccr_bank_if;
  logic wr_en;
  logic [5:0] wr_index;
  logic [15:0] wr_data;
  logic [1:0] wr_strb;
  logic wr_hit;
  logic [5:0] rd_index;
  logic [15:0] rd_data;
  logic rd_hit;
  logic [15:0] words [acccr_pkg::REG_COUNT];
  modport bank (input wr_en, wr_index, wr_data, wr_strb, rd_index,
                output wr_hit, rd_data, rd_hit, words);
  modport ctrl (output wr_en, wr_index, wr_data, wr_strb, rd_index,
                input wr_hit, rd_data, rd_hit, words);
endinterface

// ==== design/acccr_pkg.sv ====
// Register map, field layout and reset values of the channel trim register bank
package acccr_pkg;
  localparam int REG_COUNT = 6;
  localparam int TRIM_W = 24;
  localparam logic [5:0] IDX_CH2_GAIN_HI = 6'h16;
  localparam logic [5:0] IDX_CH2_GAIN_LO = 6'h17;
  localparam logic [5:0] IDX_CH3_CONFIG = 6'h18;
  localparam logic [5:0] IDX_CH3_OFFSET_HI = 6'h19;
  localparam logic [5:0] IDX_CH3_OFFSET_LO = 6'h1A;
  localparam logic [5:0] IDX_CH3_GAIN_HI = 6'h1B;
  localparam logic [5:0] IDX_NONE = 6'h3F;
  localparam logic [15:0] RST_CH2_GAIN_HI = 16'h8000;
  localparam logic [15:0] RST_CH2_GAIN_LO = 16'h0000;
  localparam logic [15:0] RST_CH3_CONFIG = 16'h0000;
  localparam logic [15:0] RST_CH3_OFFSET_HI = 16'h0000;
  localparam logic [15:0] RST_CH3_OFFSET_LO = 16'h0000;
  localparam logic [15:0] RST_CH3_GAIN_HI = 16'h8000;
  localparam logic [15:0] WMASK_FULL = 16'hFFFF;
  localparam logic [15:0] WMASK_LOW_WORD = 16'hFF00;
  localparam logic [15:0] WMASK_CONFIG = 16'hFFC7;
  localparam int CFG_DELAY_LSB = 6;
  localparam int CFG_DELAY_W = 10;
  localparam int CFG_DC_OFF_BIT = 2;
  localparam int CFG_SEL_LSB = 0;
  localparam int LOW_FIELD_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SEL_OWN_PAIR = 2'h0,
    SEL_SHORTED = 2'h1,
    SEL_POS_TEST = 2'h2,
    SEL_NEG_TEST = 2'h3
  } acccr_sel_type;
endpackage

// ==== design/acccr_reg_bank.sv ====
// Storage of the six 16-bit trim and configuration words
`timescale 1ns/1ps
module acccr_reg_bank (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  acccr_bank_if.bank bus
);
  function automatic logic [15:0] word_mask(input logic [5:0] idx);
    case (idx)
      acccr_pkg::IDX_CH2_GAIN_LO, acccr_pkg::IDX_CH3_OFFSET_LO: word_mask = acccr_pkg::WMASK_LOW_WORD;
      acccr_pkg::IDX_CH3_CONFIG: word_mask = acccr_pkg::WMASK_CONFIG;
      default: word_mask = acccr_pkg::WMASK_FULL;
    endcase
  endfunction

  function automatic logic [15:0] word_reset(input logic [5:0] idx);
    case (idx)
      acccr_pkg::IDX_CH2_GAIN_HI: word_reset = acccr_pkg::RST_CH2_GAIN_HI;
      acccr_pkg::IDX_CH2_GAIN_LO: word_reset = acccr_pkg::RST_CH2_GAIN_LO;
      acccr_pkg::IDX_CH3_CONFIG: word_reset = acccr_pkg::RST_CH3_CONFIG;
      acccr_pkg::IDX_CH3_OFFSET_HI: word_reset = acccr_pkg::RST_CH3_OFFSET_HI;
      acccr_pkg::IDX_CH3_OFFSET_LO: word_reset = acccr_pkg::RST_CH3_OFFSET_LO;
      default: word_reset = acccr_pkg::RST_CH3_GAIN_HI;
    endcase
  endfunction

  function automatic logic in_range(input logic [5:0] idx);
    in_range = (idx >= acccr_pkg::IDX_CH2_GAIN_HI) && (idx <= acccr_pkg::IDX_CH3_GAIN_HI);
  endfunction

  wire [15:0] lane_mask = {{8{bus.wr_strb[1]}}, {8{bus.wr_strb[0]}}};
  wire [5:0] rd_slot = bus.rd_index - acccr_pkg::IDX_CH2_GAIN_HI;

  genvar i;
  for (i = 0; i < acccr_pkg::REG_COUNT; i++) begin : g_word
    localparam logic [5:0] IDX = 6'(acccr_pkg::IDX_CH2_GAIN_HI + i);
    // Reserved bits never take a write, so they keep their zero reset value
    wire [15:0] keep = lane_mask & word_mask(IDX); // RQ3
    logic [15:0] word;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        word <= word_reset(IDX); // RQ1 RQ4 RQ8 RQ9 RQ11
      end else if (clk_en && bus.wr_en && bus.wr_index == IDX) begin
        word <= (word & ~keep) | (bus.wr_data & keep); // RQ1 RQ8 RQ9 RQ10 RQ12
      end
    end
    assign bus.words[i] = word;
  end

  assign bus.wr_hit = in_range(bus.wr_index);
  assign bus.rd_hit = in_range(bus.rd_index);
  assign bus.rd_data = bus.rd_hit ? bus.words[rd_slot[2:0]] : 16'h0000;
endmodule

// ==== design/acccr_regs_top.sv ====
// AXI4-Lite slave exposing the channel 2 and channel 3 trim and configuration registers
// Operation
// [RQ1] Channel 2 gain low byte at 17h, reset zero
// [RQ2] Gain trims are unsigned 24-bit, one is 800000h
// [RQ3] Reserved bits ignore writes and read zero
// [RQ4] Channel 3 configuration at 18h resets to zero
// [RQ5] Config bits 15:6 hold signed sample delay
// [RQ6] Config bit 2 turns channel DC filter off
// [RQ7] Config bits 1:0 select channel input source
// [RQ8] Offset trim bits 23:8 at 19h, reset zero
// [RQ9] Offset trim bits 7:0 at 1Ah upper byte
// [RQ10] Gain trim bits 23:8 at 1Bh, read-write
// [RQ11] Channel 3 gain high word resets to 8000h
// [RQ12] Channel 2 gain high word holds bits 23:8
// [RQ13] Trim is high word joined with low byte; channel 3 gain trim joins its high word with 00h instead
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module acccr_regs_top #(
  parameter int ADDR_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic GLOBAL_DC_FILTER_SETTING,
  output logic [23:0] CH2_GAIN_TRIM,
  output logic [23:0] CH3_GAIN_TRIM,
  output logic [23:0] CH3_OFFSET_TRIM,
  output logic [9:0] CH3_SAMPLE_DELAY,
  output logic CH3_DC_FILTER_OFF,
  output logic CH3_DC_FILTER_ACTIVE,
  output logic [1:0] CH3_INPUT_SELECT
);
  localparam int LO = acccr_pkg::LOW_FIELD_LSB;
  localparam int DL = acccr_pkg::CFG_DELAY_LSB;
  localparam int DW = acccr_pkg::CFG_DELAY_W;
  localparam int DC = acccr_pkg::CFG_DC_OFF_BIT;
  localparam int SL = acccr_pkg::CFG_SEL_LSB;

  if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 7 and 32");
  end

  // Word slots inside the bank
  localparam int S_G2H = 0;
  localparam int S_G2L = 1;
  localparam int S_CFG = 2;
  localparam int S_O3H = 3;
  localparam int S_O3L = 4;
  localparam int S_G3H = 5;

  acccr_bank_if bus ();

  acccr_reg_bank u_bank (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .clk_en(CLK_EN),
    .bus(bus)
  );

  // Bits above the word index must be zero, otherwise the access is unmapped
  function automatic logic [5:0] to_index(input logic [ADDR_W-1:0] addr);
    logic [31:0] wide;
    wide = 32'(addr);
    if (wide[31:8] != 24'h000000) begin
      to_index = acccr_pkg::IDX_NONE;
    end else begin
      to_index = wide[7:2];
    end
  endfunction

  function automatic logic [23:0] join_trim(input logic [15:0] hi, input logic [15:0] lo);
    join_trim = {hi, lo[15:LO]}; // RQ13
  endfunction

  logic [5:0] aw_index;
  logic [15:0] w_data;
  logic [1:0] w_strb;

  wire aw_take = CLK_EN && S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_take = CLK_EN && S_AXI_WVALID && S_AXI_WREADY;
  wire b_done = CLK_EN && S_AXI_BVALID && S_AXI_BREADY;
  wire ar_take = CLK_EN && S_AXI_ARVALID && S_AXI_ARREADY;
  wire r_done = CLK_EN && S_AXI_RVALID && S_AXI_RREADY;
  // Address and data both held and no response pending
  wire wr_fire = CLK_EN && !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  wire [15:0] cfg_word = bus.words[S_CFG];

  assign bus.wr_en = wr_fire;
  assign bus.wr_index = aw_index;
  assign bus.wr_data = w_data;
  assign bus.wr_strb = w_strb;
  assign bus.rd_index = to_index(S_AXI_ARADDR);

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      S_AXI_AWREADY <= 1'b1;
      aw_index <= acccr_pkg::IDX_NONE;
    end else if (aw_take) begin
      S_AXI_AWREADY <= 1'b0;
      aw_index <= to_index(S_AXI_AWADDR);
    end else if (b_done) begin
      S_AXI_AWREADY <= 1'b1;
    end
  end

  // Upper data lanes have no storage; their strobes are ignored
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      S_AXI_WREADY <= 1'b1;
      w_data <= 16'h0000;
      w_strb <= 2'h0;
    end else if (w_take) begin
      S_AXI_WREADY <= 1'b0;
      w_data <= S_AXI_WDATA[15:0];
      w_strb <= S_AXI_WSTRB[1:0];
    end else if (b_done) begin
      S_AXI_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= acccr_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= bus.wr_hit ? acccr_pkg::RESP_OKAY : acccr_pkg::RESP_SLVERR;
    end else if (b_done) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= acccr_pkg::RESP_OKAY;
    end else if (ar_take) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {16'h0000, bus.rd_data}; // RQ3
      S_AXI_RRESP <= bus.rd_hit ? acccr_pkg::RESP_OKAY : acccr_pkg::RESP_SLVERR;
    end else if (r_done) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Values seen by the filter path lag a register write by one cycle
  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      CH2_GAIN_TRIM <= join_trim(acccr_pkg::RST_CH2_GAIN_HI, acccr_pkg::RST_CH2_GAIN_LO);
      CH3_GAIN_TRIM <= {acccr_pkg::RST_CH3_GAIN_HI, 8'h00}; // RQ11
      CH3_OFFSET_TRIM <= join_trim(acccr_pkg::RST_CH3_OFFSET_HI, acccr_pkg::RST_CH3_OFFSET_LO);
      CH3_SAMPLE_DELAY <= 10'h000;
      CH3_DC_FILTER_OFF <= 1'b0;
      CH3_DC_FILTER_ACTIVE <= 1'b0;
      CH3_INPUT_SELECT <= acccr_pkg::SEL_OWN_PAIR; // RQ4
    end else if (CLK_EN) begin
      CH2_GAIN_TRIM <= join_trim(bus.words[S_G2H], bus.words[S_G2L]); // RQ2 RQ12
      // Gain low byte of channel 3 lives outside this bank and reads as zero here
      CH3_GAIN_TRIM <= {bus.words[S_G3H], 8'h00}; // RQ10
      CH3_OFFSET_TRIM <= join_trim(bus.words[S_O3H], bus.words[S_O3L]); // RQ8 RQ9
      CH3_SAMPLE_DELAY <= cfg_word[DL +: DW]; // RQ5
      CH3_DC_FILTER_OFF <= cfg_word[DC]; // RQ6
      CH3_DC_FILTER_ACTIVE <= GLOBAL_DC_FILTER_SETTING && !cfg_word[DC]; // RQ6
      CH3_INPUT_SELECT <= cfg_word[SL +: 2]; // RQ7
    end
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);

  sequence s_wr(logic [5:0] idx, logic [1:0] strb);
    bus.wr_en && bus.wr_index == idx && bus.wr_strb == strb;
  endsequence

  chk_ch2_gain_low: assert property ( // RQ1
    s_wr(acccr_pkg::IDX_CH2_GAIN_LO, 2'h3)
    |=> bus.words[S_G2L] == {$past(bus.wr_data[15:8]), 8'h00}
  ) else $error("gain low byte not stored in bits 15:8");

  chk_gain_unity: assert property ( // RQ2
    $rose(RESETN) |-> CH3_GAIN_TRIM == 24'h800000 && CH2_GAIN_TRIM == 24'h800000
  ) else $error("gain trims do not reset to unity");

  chk_reserved_zero: assert property ( // RQ3
    bus.words[S_G2L][7:0] == 8'h00 && bus.words[S_O3L][7:0] == 8'h00
    && cfg_word[5:3] == 3'h0 && (!S_AXI_RVALID || S_AXI_RDATA[31:16] == 16'h0000)
  ) else $error("reserved bits hold a nonzero value");

  chk_config_reset: assert property ( // RQ4
    $rose(RESETN) |-> cfg_word == 16'h0000 && CH3_SAMPLE_DELAY == 10'h000
    && !CH3_DC_FILTER_OFF && CH3_INPUT_SELECT == 2'h0
  ) else $error("channel configuration not zero after reset");

  chk_sample_delay: assert property ( // RQ5
    s_wr(acccr_pkg::IDX_CH3_CONFIG, 2'h3) ##1 CLK_EN
    |=> CH3_SAMPLE_DELAY == $past(bus.wr_data[15:6], 2)
  ) else $error("sample delay does not follow config bits 15:6");

  chk_dc_filter: assert property ( // RQ6
    $past(CLK_EN) && $past(RESETN)
    |-> CH3_DC_FILTER_ACTIVE == ($past(GLOBAL_DC_FILTER_SETTING) && !$past(cfg_word[2]))
    && CH3_DC_FILTER_OFF == $past(cfg_word[2])
  ) else $error("DC filter state wrong for config bit 2");

  chk_input_select: assert property ( // RQ7
    s_wr(acccr_pkg::IDX_CH3_CONFIG, 2'h1) ##1 CLK_EN
    |=> CH3_INPUT_SELECT == $past(bus.wr_data[1:0], 2)
  ) else $error("input select does not follow config bits 1:0");

  chk_offset_high: assert property ( // RQ8
    s_wr(acccr_pkg::IDX_CH3_OFFSET_HI, 2'h3) ##1 CLK_EN
    |=> CH3_OFFSET_TRIM[23:8] == $past(bus.wr_data, 2)
  ) else $error("offset trim bits 23:8 wrong");

  chk_offset_low: assert property ( // RQ9
    s_wr(acccr_pkg::IDX_CH3_OFFSET_LO, 2'h2) ##1 CLK_EN
    |=> CH3_OFFSET_TRIM[7:0] == $past(bus.wr_data[15:8], 2)
  ) else $error("offset trim bits 7:0 wrong");

  chk_gain_high: assert property ( // RQ10
    s_wr(acccr_pkg::IDX_CH3_GAIN_HI, 2'h3) |=> bus.words[S_G3H] == $past(bus.wr_data)
  ) else $error("gain high word not written");

  chk_gain_high_reset: assert property ( // RQ11
    $rose(RESETN) |-> bus.words[S_G3H] == 16'h8000
  ) else $error("gain high word reset wrong");

  chk_ch2_gain_join: assert property ( // RQ12
    $past(CLK_EN) && $past(RESETN)
    |-> CH2_GAIN_TRIM == {$past(bus.words[S_G2H]), $past(bus.words[S_G2L][15:8])}
  ) else $error("channel 2 gain trim badly assembled");

  chk_offset_join: assert property ( // RQ13
    $past(CLK_EN) && $past(RESETN)
    |-> CH3_OFFSET_TRIM == {$past(bus.words[S_O3H]), $past(bus.words[S_O3L][15:8])}
  ) else $error("channel 3 offset trim badly assembled");

  chk_read_latency: assert property (
    ar_take |=> S_AXI_RVALID && !S_AXI_ARREADY
  ) else $error("read data not valid one cycle after address");

  chk_bresp_hold: assert property (
    S_AXI_BVALID && !b_done |=> S_AXI_BVALID && $stable(S_AXI_BRESP)
  ) else $error("write response dropped before handshake");

  chk_write_latency: assert property (
    wr_fire |=> S_AXI_BVALID && !S_AXI_AWREADY && !S_AXI_WREADY
  ) else $error("write response not raised after address and data");

  chk_ready_return: assert property (
    b_done |=> S_AXI_AWREADY && S_AXI_WREADY && !S_AXI_BVALID
  ) else $error("write channels not reopened after response");

  chk_unmapped_write: assert property (
    wr_fire && !bus.wr_hit |=> S_AXI_BRESP == acccr_pkg::RESP_SLVERR
  ) else $error("unmapped write not refused");

  chk_unmapped_read: assert property (
    ar_take && !bus.rd_hit |=> S_AXI_RRESP == acccr_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h00000000
  ) else $error("unmapped read not refused");

  chk_rdata_hold: assert property (
    S_AXI_RVALID && !r_done |=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP)
  ) else $error("read response changed before handshake");

  chk_enable_freeze: assert property (
    !CLK_EN |=> $stable(cfg_word) && $stable(CH2_GAIN_TRIM) && $stable(CH3_OFFSET_TRIM)
    && $stable(S_AXI_AWREADY) && $stable(S_AXI_ARREADY) && $stable(S_AXI_BVALID)
  ) else $error("state moved while the clock enable was low");

  chk_no_stray_write: assert property (
    !wr_fire |=> $stable(bus.words[S_G2H]) && $stable(bus.words[S_O3H])
    && $stable(bus.words[S_G3H])
  ) else $error("stored word changed without a write");

  cov_cfg_write: cover property (s_wr(acccr_pkg::IDX_CH3_CONFIG, 2'h3));
  cov_neg_test: cover property (CH3_INPUT_SELECT == acccr_pkg::SEL_NEG_TEST);
  cov_unmapped: cover property (r_done && S_AXI_RRESP == acccr_pkg::RESP_SLVERR);
  cov_resp_wait: cover property (S_AXI_BVALID && !S_AXI_BREADY ##1 b_done);
endmodule

// ==== tb/testbench.sv ====
// Self-checking testbench for the channel trim register bank over AXI4-Lite
`timescale 1ns/1ps
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  logic SYS_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic CLK_EN = 1'b1;
  logic GLOBAL_DC_FILTER_SETTING = 1'b0;
  logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
  logic aw_valid = 1'b0, w_valid = 1'b0, ar_valid = 1'b0;
  logic [31:0] w_data = 32'h00000000;
  logic [3:0] w_strb = 4'h0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, ch3_off, ch3_active;
  logic [1:0] b_resp, r_resp, ch3_sel;
  logic [31:0] r_data;
  logic [23:0] ch2_gain, ch3_gain, ch3_offset;
  logic [9:0] ch3_delay;
  int failures = 0;
  int tests_run = 0;
  integer seed = 90;
  logic stall = 1'b0;
  logic b_ready = 1'b1, r_ready = 1'b1;
  logic [1:0] wq [$];
  logic [33:0] rq [$];
  logic [1:0] exp_b;
  logic [33:0] exp_r;
  logic [15:0] mem [6];

  acccr_regs_top #(.ADDR_W(8)) dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN),
    .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data),
    .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp),
    .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid),
    .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid),
    .S_AXI_RREADY(r_ready), .GLOBAL_DC_FILTER_SETTING(GLOBAL_DC_FILTER_SETTING), .CH2_GAIN_TRIM(ch2_gain),
    .CH3_GAIN_TRIM(ch3_gain), .CH3_OFFSET_TRIM(ch3_offset), .CH3_SAMPLE_DELAY(ch3_delay),
    .CH3_DC_FILTER_OFF(ch3_off), .CH3_DC_FILTER_ACTIVE(ch3_active), .CH3_INPUT_SELECT(ch3_sel));

  initial begin
    forever #4 SYS_CLK = ~SYS_CLK;
  end

  // Random enable gaps while stall is set stretch handshakes without changing any result
  always @(posedge SYS_CLK) begin
    CLK_EN <= stall ? 1'($random(seed)) : 1'b1;
  end

  // Response monitor: oldest note is compared when a response is accepted
  always @(posedge SYS_CLK) begin
    if (RESETN && CLK_EN && b_valid && b_ready) begin
      exp_b = (wq.size() > 0) ? wq.pop_front() : 2'h3;
      `CHECK(b_resp, exp_b)
    end
    if (RESETN && CLK_EN && r_valid && r_ready) begin
      exp_r = (rq.size() > 0) ? rq.pop_front() : {2'h3, 32'hFFFFFFFF};
      `CHECK({r_resp, r_data}, exp_r)
    end
  end

  function automatic logic [15:0] wmask(input int i);
    case (i)
      1, 4: return acccr_pkg::WMASK_LOW_WORD;
      2: return acccr_pkg::WMASK_CONFIG;
      default: return acccr_pkg::WMASK_FULL;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    logic [15:0] m;
    logic aw_done, w_done;
    i = int'(a[7:2]) - 22;
    m = {{8{s[1]}}, {8{s[0]}}} & wmask(i);
    if (i >= 0 && i < 6) begin
      mem[i] = (mem[i] & ~m) | (d[15:0] & m);
      wq.push_back(acccr_pkg::RESP_OKAY);
    end else begin
      wq.push_back(acccr_pkg::RESP_SLVERR);
    end
    aw_done = 1'b0;
    w_done = 1'b0;
    aw_addr <= a;
    w_data <= d;
    w_strb <= s;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= !stall;
    while (!(aw_done && w_done)) begin
      @(posedge SYS_CLK);
      if (!aw_done && aw_ready && CLK_EN) begin
        aw_done = 1'b1;
        aw_valid <= 1'b0;
      end
      if (!w_done && w_ready && CLK_EN) begin
        w_done = 1'b1;
        w_valid <= 1'b0;
      end
    end
    // Under stall the response is made to wait, then ready is held until it is taken
    if (stall) begin
      repeat (2'($random(seed))) @(posedge SYS_CLK);
      b_ready <= 1'b1;
    end
    do @(posedge SYS_CLK); while (!(b_valid && b_ready && CLK_EN));
  endtask

  task automatic rd(input logic [7:0] a);
    int i;
    i = int'(a[7:2]) - 22;
    if (i >= 0 && i < 6) rq.push_back({acccr_pkg::RESP_OKAY, 16'h0000, mem[i]});
    else rq.push_back({acccr_pkg::RESP_SLVERR, 32'h00000000});
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= !stall;
    do @(posedge SYS_CLK); while (!(ar_ready && CLK_EN));
    ar_valid <= 1'b0;
    if (stall) begin
      repeat (2'($random(seed))) @(posedge SYS_CLK);
      r_ready <= 1'b1;
    end
    do @(posedge SYS_CLK); while (!(r_valid && r_ready && CLK_EN));
  endtask

  task automatic rd_all();
    for (int a = 'h58; a <= 'h6C; a += 4) rd(8'(a));
  endtask

  // Trim outputs lag the stored words by one enabled clock, so two edges are allowed
  task automatic chk_outs();
    repeat (2) @(posedge SYS_CLK);
    `CHECK(ch2_gain, {mem[0], mem[1][15:8]})
    `CHECK(ch3_gain, {mem[5], 8'h00})
    `CHECK(ch3_offset, {mem[3], mem[4][15:8]})
    `CHECK(ch3_delay, mem[2][15:6])
    `CHECK(ch3_off, mem[2][2])
    `CHECK(ch3_active, GLOBAL_DC_FILTER_SETTING & ~mem[2][2])
    `CHECK(ch3_sel, mem[2][1:0])
  endtask

  task automatic do_reset();
    RESETN <= 1'b0;
    repeat (16) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    @(posedge SYS_CLK);
    mem = '{16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000};
  endtask

  task automatic report_and_stop();
    $display("Checks made %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge SYS_CLK);
    failures++;
    $display("Error at %0t: run did not finish in time", $time);
    report_and_stop();
  end

  initial begin
    logic [7:0] a;
    do_reset();
    chk_outs();
    rd_all();
    $display("Test reset values done");
    for (int a2 = 'h58; a2 <= 'h6C; a2 += 4) begin
      wr(8'(a2), 32'hFFFFFFFF, 4'hF);
      rd(8'(a2));
      chk_outs();
    end
    $display("Test all ones and reserved bits done");
    for (int sel = 0; sel < 4; sel++) begin
      for (int off = 0; off < 2; off++) begin
        GLOBAL_DC_FILTER_SETTING <= 1'(sel);
        wr(8'h60, {16'h0000, 10'($random(seed)), 3'b111, 1'(off), 2'(sel)}, 4'hF);
        rd(8'h60);
        chk_outs();
      end
    end
    $display("Test configuration fields done");
    for (int s = 0; s < 4; s++) begin
      wr(8'h6C, $random(seed), {2'b10, 2'(s)});
      wr(8'h68, $random(seed), {2'b01, 2'(s)});
      rd(8'h6C);
      rd(8'h68);
    end
    chk_outs();
    $display("Test byte strobes done");
    foreach (mem[k]) begin
      a = (k < 4) ? 8'(8'h00 + k * 8'h54) : 8'(8'h70 + k * 8'h04);
      wr(a, $random(seed), 4'hF);
      rd(a);
    end
    rd_all();
    chk_outs();
    $display("Test unmapped addresses done");
    stall = 1'b1;
    repeat (150) begin
      a = 8'h50 + {3'b000, 3'($random(seed)), 2'b00};
      if (1'($random(seed))) wr(a, $random(seed), 4'($random(seed)));
      else rd(a);
    end
    stall = 1'b0;
    rd_all();
    chk_outs();
    $display("Test random traffic with stalls done");
    do_reset();
    chk_outs();
    rd_all();
    $display("Test second reset done");
    repeat (4) @(posedge SYS_CLK);
    report_and_stop();
  end
endmodule
